/* File: fcrc_ctrl.sv */
// Flash CPU rewrite control: control registers, command sequencer and Avalon-MM slave.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

module fcrc_ctrl
    import fcrc_pkg::*;
(
    input  wire logic                          clk_in,
    input  wire logic                          nrst_in,
    input  wire logic [fcrc_pkg::ADDR_W-1:0]   address_in,
    input  wire logic                          read_in,
    input  wire logic                          write_in,
    input  wire logic [fcrc_pkg::DATA_W-1:0]   writedata_in,
    input  wire logic [3:0]                    byteenable_in,
    output var  logic [fcrc_pkg::DATA_W-1:0]   readdata_out,
    output var  logic                          waitrequest_out,
    input  wire logic                          nmi_req_in,
    input  wire logic                          wdt_req_in,
    input  wire logic                          nmi_pin_in,
    input  wire logic                          boot_mode_in,
    input  wire logic                          low_power_in,
    input  wire logic                          op_done_in,
    input  wire logic                          op_fail_in,
    input  wire logic                          lock_bit_in,
    input  wire logic                          block_locked_in,
    output var  logic                          op_start_out,
    output var  logic [7:0]                    op_cmd_out,
    output var  logic [15:0]                   op_data_out,
    output var  logic                          op_abort_out,
    output var  logic                          block_unlock_out,
    output var  logic                          lock_ignore_out,
    output var  logic                          flash_reset_out,
    output var  logic                          flash_power_off_out,
    output var  logic                          rewrite_mode_out,
    output var  logic                          mode_one_out,
    output var  logic                          user_area_out
);
    import fcrc_pkg::*;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic        rewrite_enable;
    logic        lock_override;
    logic        erase_write_mode_select;
    logic        flash_stop;
    logic        user_area_select;
    logic        program_error_flag;
    logic        erase_error_flag;
    logic        lock_status_flag;
    fcrc_state_t st_q;
    fcrc_state_t next_st;
    logic [7:0]  cmd_q;

    // A request is taken on the edge where waitrequest is already low.
    wire       acc      = (read_in || write_in) && !waitrequest_out;
    wire       wr_acc   = acc && write_in && byteenable_in[0];
    wire       wr_ctl0  = wr_acc && (address_in == OFF_CTL0);
    wire       wr_ctl1  = wr_acc && (address_in == OFF_CTL1);
    wire       wr_cmd   = wr_acc && (address_in == OFF_CMD);
    wire [7:0] wbyte    = writedata_in[7:0];
    wire       force_rst = nmi_req_in || wdt_req_in;
    wire       stop_eff = flash_stop && rewrite_enable;
    wire       ready_flag = (st_q != ST_BUSY);

    // Guarded writes need the NMI pin high; a write with it low is dropped.
    wire       g_wr0    = wr_ctl0 && nmi_pin_in;
    wire       g_wr1    = wr_ctl1 && nmi_pin_in;
    wire       rew_clr  = g_wr0 && !wbyte[C0_REWRITE];

    // ------------------------------------------------------------------
    // Guarded control bits
    // ------------------------------------------------------------------
    fcrc_guard_bit u_rewrite (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .wr_in    (g_wr0),
        .wdata_in (wbyte[C0_REWRITE]),
        .allow_in (1'b1),
        .clear_in (force_rst),
        .bit_out  (rewrite_enable)
    );

    fcrc_guard_bit u_lock_ovr (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .wr_in    (g_wr0),
        .wdata_in (wbyte[C0_LOCK_OVR]),
        .allow_in (1'b1),
        .clear_in (force_rst),
        .bit_out  (lock_override)
    );

    // Mode one may only be chosen once rewrite mode is on; leaving it drops back.
    fcrc_guard_bit u_ewsel (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .wr_in    (g_wr1),
        .wdata_in (wbyte[C1_EWSEL]),
        .allow_in (rewrite_enable),
        .clear_in (force_rst || rew_clr),
        .bit_out  (erase_write_mode_select)
    );

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    // Commands are dropped while rewrite is off or the flash is stopped.
    wire cmd_ok     = wr_cmd && rewrite_enable && !stop_eff;
    wire two_cycle  = (wbyte == CMD_PROGRAM) || (wbyte == CMD_ERASE) ||
                      (wbyte == CMD_ERASE_ALL) || (wbyte == CMD_LOCK_PROG) ||
                      (wbyte == CMD_LOCK_READ);
    wire is_clear   = cmd_ok && (st_q == ST_IDLE) && (wbyte == CMD_CLEAR);
    wire arg_wr     = cmd_ok && (st_q == ST_ARG);
    wire confirm_ok = (cmd_q == CMD_PROGRAM) || (wbyte == CMD_CONFIRM);
    wire prot_cmd   = (cmd_q == CMD_PROGRAM) || (cmd_q == CMD_ERASE);
    // Per-block protection applies unless the override is set.
    wire refused    = prot_cmd && block_locked_in && !lock_override;
    wire start      = arg_wr && confirm_ok && !refused;
    wire refuse_hit = arg_wr && confirm_ok && refused;
    wire is_erase   = (cmd_q == CMD_ERASE) || (cmd_q == CMD_ERASE_ALL);
    wire is_prog    = (cmd_q == CMD_PROGRAM) || (cmd_q == CMD_LOCK_PROG);
    wire done       = (st_q == ST_BUSY) && op_done_in;
    wire abort      = force_rst || stop_eff;

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    // An abort wins over every other transition so a hung array is left behind.
    always_comb begin
        next_st = st_q;
        if (abort) begin
            next_st = ST_IDLE;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (cmd_ok && two_cycle) begin
                        next_st = ST_ARG;
                    end
                end
                ST_ARG: begin
                    if (start) begin
                        next_st = ST_BUSY;
                    end else if (arg_wr) begin
                        next_st = ST_IDLE;
                    end
                end
                ST_BUSY: begin
                    if (op_done_in) begin
                        next_st = ST_IDLE;
                    end
                end
                default: begin
                    next_st = ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Error and lock flags
    // ------------------------------------------------------------------
    // Hardware sets of the error flags win over a clear in the same cycle.
    wire set_perr = (done && op_fail_in && is_prog) || (refuse_hit && is_prog);
    wire set_eerr = (done && op_fail_in && is_erase) || (refuse_hit && is_erase);
    wire next_perr = set_perr || (program_error_flag && !is_clear && !force_rst);
    wire next_eerr = set_eerr || (erase_error_flag && !is_clear && !force_rst);
    wire next_lock = (done && (cmd_q == CMD_LOCK_READ)) ? lock_bit_in : lock_status_flag;
    wire next_unl  = done && !op_fail_in && is_erase && lock_override;

    // ------------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------------
    logic [7:0] ctl0_rd;
    logic [7:0] ctl1_rd;
    logic [7:0] stat_rd;

    always_comb begin
        ctl0_rd = 8'h00;
        ctl0_rd[C0_READY]    = ready_flag;
        ctl0_rd[C0_REWRITE]  = rewrite_enable;
        ctl0_rd[C0_LOCK_OVR] = lock_override;
        ctl0_rd[C0_STOP]     = flash_stop;
        ctl0_rd[C0_USER]     = user_area_select;
        ctl0_rd[C0_PERR]     = program_error_flag;
        ctl0_rd[C0_EERR]     = erase_error_flag;
        ctl1_rd = 8'h00;
        ctl1_rd[C1_EWSEL]    = erase_write_mode_select;
        ctl1_rd[C1_LOCKSTAT] = lock_status_flag;
        // The status view is hidden in mode one; software polls the flags instead.
        stat_rd = 8'h00;
        if (!erase_write_mode_select) begin
            stat_rd[SR_READY] = ready_flag;
            stat_rd[SR_PERR]  = program_error_flag;
            stat_rd[SR_EERR]  = erase_error_flag;
        end
    end

    wire [7:0] rd_byte = (address_in == OFF_CTL0)   ? ctl0_rd :
                         (address_in == OFF_CTL1)   ? ctl1_rd :
                         (address_in == OFF_STATUS) ? stat_rd : 8'h00;
    wire       load_rd = read_in && waitrequest_out;
    wire       next_wait = !((read_in || write_in) && waitrequest_out);

    // ------------------------------------------------------------------
    // Plain control bits, sequencer and bus state
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flash_stop         <= CTL0_RESET[C0_STOP];
            user_area_select   <= CTL0_RESET[C0_USER];
            program_error_flag <= CTL0_RESET[C0_PERR];
            erase_error_flag   <= CTL0_RESET[C0_EERR];
            lock_status_flag   <= CTL1_RESET[C1_LOCKSTAT];
            st_q               <= ST_IDLE;
            cmd_q              <= CMD_READ_ARRAY;
            waitrequest_out    <= 1'b1;
            readdata_out       <= '0;
        end else begin
            if (force_rst) begin
                flash_stop       <= CTL0_RESET[C0_STOP];
                user_area_select <= CTL0_RESET[C0_USER];
            end else if (wr_ctl0) begin
                flash_stop       <= wbyte[C0_STOP];
                user_area_select <= wbyte[C0_USER];
            end
            program_error_flag <= next_perr;
            erase_error_flag   <= next_eerr;
            lock_status_flag   <= force_rst ? CTL1_RESET[C1_LOCKSTAT] : next_lock;
            st_q               <= next_st;
            if (cmd_ok && (st_q == ST_IDLE)) begin
                cmd_q <= wbyte;
            end
            waitrequest_out <= next_wait;
            if (load_rd) begin
                readdata_out <= {{(DATA_W-8){1'b0}}, rd_byte};
            end
        end
    end

    // ------------------------------------------------------------------
    // Flash-side outputs
    // ------------------------------------------------------------------
    // Every output is registered so the array sees clean levels and pulses.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            op_start_out        <= 1'b0;
            op_cmd_out          <= CMD_READ_ARRAY;
            op_data_out         <= 16'h0000;
            op_abort_out        <= 1'b0;
            block_unlock_out    <= 1'b0;
            lock_ignore_out     <= 1'b0;
            flash_reset_out     <= 1'b0;
            flash_power_off_out <= 1'b0;
            rewrite_mode_out    <= 1'b0;
            mode_one_out        <= 1'b0;
            user_area_out       <= 1'b0;
        end else begin
            op_start_out <= start && !abort;
            if (start) begin
                op_cmd_out  <= cmd_q;
                op_data_out <= writedata_in[15:0];
            end
            op_abort_out        <= abort && (st_q == ST_BUSY);
            block_unlock_out    <= next_unl && !abort;
            lock_ignore_out     <= lock_override;
            flash_reset_out     <= stop_eff;
            flash_power_off_out <= stop_eff || low_power_in;
            rewrite_mode_out    <= rewrite_enable;
            mode_one_out        <= erase_write_mode_select;
            // Outside boot mode the user area is always mapped.
            user_area_out       <= !boot_mode_in || user_area_select;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_clear_cmd;
        is_clear && !set_perr && !set_eerr;
    endsequence

    sequence s_erase_unlock_done;
        done && !op_fail_in && is_erase && lock_override && !abort;
    endsequence

    cmd_gate_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $rose(op_start_out) |-> $past(rewrite_enable) && $past(st_q == ST_ARG))
        else $error("operation started outside rewrite mode");

    ewsel_needs_rew_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $rose(erase_write_mode_select) |-> $past(rewrite_enable))
        else $error("mode one set while rewrite off");

    ewsel_clear_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $fell(rewrite_enable) |-> !erase_write_mode_select)
        else $error("mode select survived rewrite clear");

    ready_busy_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        op_start_out |-> !ready_flag ##0 (!ready_flag || $past(op_done_in) || $past(abort)))
        else $error("ready flag high while operation runs");

    unlock_pulse_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_erase_unlock_done |=> block_unlock_out ##1 !block_unlock_out)
        else $error("lock bits not released after override erase");

    stop_reset_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (flash_stop && !force_rst) |=> (flash_reset_out == $past(rewrite_enable)) && st_q != ST_BUSY
            || !$past(rewrite_enable))
        else $error("flash stop did not follow rewrite enable");

    status_hide_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (load_rd && address_in == OFF_STATUS && erase_write_mode_select) |=> readdata_out == '0)
        else $error("status readable in mode one");

    clear_status_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_clear_cmd |=> !program_error_flag && !erase_error_flag)
        else $error("clear command left an error flag");

    nmi_reset_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        force_rst |=> !rewrite_enable && !lock_override && !erase_write_mode_select
            && !flash_stop && st_q == ST_IDLE)
        else $error("interrupt did not reset control registers");

endmodule : fcrc_ctrl

`default_nettype wire

/* File: fcrc_pkg.sv */
// Constants shared by the flash CPU rewrite control block.
`default_nettype none
package fcrc_pkg;

    // ------------------------------------------------------------------
    // Bus geometry and register byte offsets
    // ------------------------------------------------------------------
    localparam int          ADDR_W      = 4;
    localparam int          DATA_W      = 32;
    localparam logic [3:0]  OFF_CTL0    = 4'h0;   // flash_control_0
    localparam logic [3:0]  OFF_CTL1    = 4'h4;   // flash_control_1
    localparam logic [3:0]  OFF_CMD     = 4'h8;   // Software command port.
    localparam logic [3:0]  OFF_STATUS  = 4'hc;   // Status register view.

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          C0_READY    = 0;
    localparam int          C0_REWRITE  = 1;
    localparam int          C0_LOCK_OVR = 2;
    localparam int          C0_STOP     = 3;
    localparam int          C0_USER     = 5;
    localparam int          C0_PERR     = 6;
    localparam int          C0_EERR     = 7;
    localparam int          C1_EWSEL    = 1;
    localparam int          C1_LOCKSTAT = 6;
    localparam int          SR_PERR     = 4;
    localparam int          SR_EERR     = 5;
    localparam int          SR_READY    = 7;
    localparam logic [7:0]  CTL0_RESET  = 8'h01;
    localparam logic [7:0]  CTL1_RESET  = 8'h00;

    // ------------------------------------------------------------------
    // Software command codes (low byte of the written word)
    // ------------------------------------------------------------------
    localparam logic [7:0]  CMD_READ_ARRAY  = 8'hff;
    localparam logic [7:0]  CMD_READ_STATUS = 8'h70;
    localparam logic [7:0]  CMD_CLEAR       = 8'h50;
    localparam logic [7:0]  CMD_PROGRAM     = 8'h40;
    localparam logic [7:0]  CMD_ERASE       = 8'h20;
    localparam logic [7:0]  CMD_ERASE_ALL   = 8'ha7;
    localparam logic [7:0]  CMD_LOCK_PROG   = 8'h77;
    localparam logic [7:0]  CMD_LOCK_READ   = 8'h71;
    localparam logic [7:0]  CMD_CONFIRM     = 8'hd0;

    // ------------------------------------------------------------------
    // Command sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARG  = 3'b010,
        ST_BUSY = 3'b100
    } fcrc_state_t;

endpackage : fcrc_pkg

`default_nettype wire

/* File: fcrc_guard_bit.sv */
// Control bit that only sets after a write of 0 directly followed by a write of 1.
`timescale 1ns/10ps
`default_nettype none

module fcrc_guard_bit (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic wr_in,
    input  wire logic wdata_in,
    input  wire logic allow_in,
    input  wire logic clear_in,
    output var  logic bit_out
);

    // ------------------------------------------------------------------
    // Arm on a write of 0; any other write disarms.
    // ------------------------------------------------------------------
    logic armed;
    wire  set_ok = wr_in && wdata_in && armed && allow_in;

    // A lone write of 1 finds the guard disarmed and changes nothing.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            armed   <= 1'b0;
            bit_out <= 1'b0;
        end else begin
            if (clear_in || wr_in) begin
                armed <= wr_in && !wdata_in && !clear_in;
            end
            if (clear_in || (wr_in && !wdata_in)) begin
                bit_out <= 1'b0;
            end else if (set_ok) begin
                bit_out <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_rise_needs_arm;
        @(posedge clk_in) disable iff (!nrst_in)
        $rose(bit_out) |-> $past(armed) && $past(wr_in) && $past(wdata_in);
    endproperty
    guard_sequence_a: assert property (p_rise_needs_arm) else $error("guarded bit set without 0 then 1");

    lone_one_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (wr_in && wdata_in && !armed && !bit_out) |=> !bit_out) else $error("lone write of 1 set the bit");

endmodule : fcrc_guard_bit

`default_nettype wire

/* File: fcrc_flash_model.sv */
// Behavioural flash array that answers each started operation after a fixed delay.
`timescale 1ns/10ps
`default_nettype none
module fcrc_flash_model (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic start_in,
    input  wire logic fail_in,
    output var  logic done_out,
    output var  logic fail_out,
    output var  logic lock_out
);
    logic [4:0] cnt;
    // A slow answer keeps the ready flag low long enough for software to read it.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt <= 5'h00;
        end else if (start_in) begin
            cnt <= 5'h14;
        end else if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
        end
    end
    // Results only mean something while done is high; lock reads report an unlocked block.
    assign done_out = (cnt == 5'h01);
    assign fail_out = done_out & fail_in;
    assign lock_out = done_out;
endmodule : fcrc_flash_model
`default_nettype wire

/* File: test_fcrc_ctrl.sv */
// Self-checking bench for the flash CPU rewrite control block.
`timescale 1ns/10ps
`default_nettype none
module test_fcrc_ctrl;
    import fcrc_pkg::*;
    logic        clk_in = 1'b0, nrst_in = 1'b0, rd = 1'b0, wr = 1'b0, fail = 1'b0;
    logic [1:0]  abort_req = 2'b00;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic        waitreq, start, done, ofail, lockb, unl, abt;
    logic [31:0] expq[$];
    int          mismatches = 0, checks_done = 0, cycles = 0, seed = 32'h3702;
    int          unl_cnt = 0, abt_cnt = 0;
    fcrc_ctrl u_fcrc_ctrl (.clk_in(clk_in), .nrst_in(nrst_in), .address_in(addr), .read_in(rd), .write_in(wr),
        .writedata_in(wdata), .byteenable_in(4'hf), .readdata_out(rdata), .waitrequest_out(waitreq),
        .nmi_req_in(abort_req[0]), .wdt_req_in(abort_req[1]), .nmi_pin_in(1'b1), .boot_mode_in(1'b0),
        .low_power_in(1'b0), .op_done_in(done), .op_fail_in(ofail), .lock_bit_in(lockb),
        .block_locked_in(1'b0), .op_start_out(start), .op_cmd_out(), .op_data_out(), .op_abort_out(abt),
        .block_unlock_out(unl), .lock_ignore_out(), .flash_reset_out(), .flash_power_off_out(),
        .rewrite_mode_out(), .mode_one_out(), .user_area_out());
    fcrc_flash_model u_fcrc_flash_model (.clk_in(clk_in), .nrst_in(nrst_in), .start_in(start),
        .fail_in(fail), .done_out(done), .fail_out(ofail), .lock_out(lockb));
    always #2 clk_in = ~clk_in;
    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // An edge passes before each request so a strobe is never assigned twice in one step.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do @(posedge clk_in); while (waitreq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rdc
    // No interrupt request is raised between the two writes, and the pin stays high.
    task automatic arm(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, 32'h0);
        bus(1'b1, a, d);
    endtask : arm
    task automatic op(input logic [7:0] c, input logic [31:0] d);
        bus(1'b1, OFF_CMD, {24'h0, c});
        bus(1'b1, OFF_CMD, d);
        rdc(OFF_CTL0, 32'h02);
        // Nothing else crosses the bus while the array is busy.
        do @(posedge clk_in); while (done !== 1'b1);
    endtask : op
    // The oldest expectation is taken at the edge where read data is accepted.
    always @(posedge clk_in) begin
        cycles++;
        if (unl === 1'b1) unl_cnt++;
        if (abt === 1'b1) abt_cnt++;
        if (rd && waitreq === 1'b0) chk(rdata, expq.pop_front());
        if (cycles == 5000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        repeat (4) @(posedge clk_in);
        nrst_in <= 1'b1;
        rdc(OFF_CTL0, 32'h01);
        rdc(OFF_CTL1, 32'h00);
        bus(1'b1, OFF_CTL0, 32'h02);
        rdc(OFF_CTL0, 32'h01);
        arm(OFF_CTL1, 32'h02);
        rdc(OFF_CTL1, 32'h00);
        bus(1'b1, OFF_CMD, {24'h0, CMD_PROGRAM});
        bus(1'b1, OFF_CMD, $random(seed));
        rdc(OFF_CTL0, 32'h01);
        arm(OFF_CTL0, 32'h02);
        arm(OFF_CTL1, 32'h02);
        rdc(OFF_CTL1, 32'h02);
        bus(1'b1, OFF_CTL0, 32'h00);
        rdc(OFF_CTL1, 32'h00);
        arm(OFF_CTL0, 32'h02);
        rdc(OFF_CTL0, 32'h03);
        fail <= 1'b1;
        op(CMD_PROGRAM, $random(seed));
        rdc(OFF_CTL0, 32'h43);
        rdc(OFF_STATUS, 32'h90);
        bus(1'b1, OFF_CMD, {24'h0, CMD_CLEAR});
        rdc(OFF_CTL0, 32'h03);
        rdc(OFF_STATUS, 32'h80);
        op(CMD_ERASE, {24'h0, CMD_CONFIRM});
        rdc(OFF_CTL0, 32'h83);
        bus(1'b1, OFF_CMD, {24'h0, CMD_CLEAR});
        fail <= 1'b0;
        op(CMD_LOCK_READ, {24'h0, CMD_CONFIRM});
        rdc(OFF_CTL1, 32'h40);
        arm(OFF_CTL0, 32'h06);
        bus(1'b1, OFF_CMD, {24'h0, CMD_ERASE});
        bus(1'b1, OFF_CMD, {24'h0, CMD_CONFIRM});
        rdc(OFF_CTL0, 32'h06);
        do @(posedge clk_in); while (done !== 1'b1);
        rdc(OFF_CTL0, 32'h07);
        chk(unl_cnt, 32'h1);
        // A running program is cut short by the stop bit.
        bus(1'b1, OFF_CMD, {24'h0, CMD_PROGRAM});
        bus(1'b1, OFF_CMD, $random(seed));
        bus(1'b1, OFF_CTL0, 32'h0a);
        rdc(OFF_CTL0, 32'h0b);
        chk(abt_cnt, 32'h1);
        bus(1'b1, OFF_CTL0, 32'h02);
        arm(OFF_CTL1, 32'h02);
        rdc(OFF_STATUS, 32'h00);
        for (int i = 1; i < 3; i++) begin
            abort_req <= i[1:0];
            @(posedge clk_in);
            abort_req <= 2'b00;
            rdc(OFF_CTL0, 32'h01);
            rdc(OFF_CTL1, 32'h00);
            arm(OFF_CTL0, 32'h02);
        end
        conclude();
    end
endmodule : test_fcrc_ctrl
`default_nettype wire
